// ### core/lpp_pkg.sv
// package: register map, field layout and timing for the bus phy protection block
package lpp_pkg;

  // register offsets (byte addresses on the plain register port)
  localparam logic [2:0] LPP_OFF_CTRL     = 3'h1;
  localparam logic [2:0] LPP_OFF_TEST     = 3'h2;
  localparam logic [2:0] LPP_OFF_SLEW     = 3'h3;
  localparam logic [2:0] LPP_OFF_STATUS   = 3'h5;
  localparam logic [2:0] LPP_OFF_IRQ_EN   = 3'h6;
  localparam logic [2:0] LPP_OFF_IRQ_FLAG = 3'h7;

  // field positions
  localparam int LPP_BIT_ENABLE   = 3;
  localparam int LPP_BIT_RECEIVE_ONLY_SEL   = 2;
  localparam int LPP_BIT_TODIS    = 7;
  localparam int LPP_BIT_SLEW_HI  = 1;
  localparam int LPP_BIT_SLEW_LO  = 0;
  localparam int LPP_BIT_STILLDOM = 7;
  localparam int LPP_BIT_TO       = 7;
  localparam int LPP_BIT_OC       = 6;

  // reset values
  localparam logic [7:0] LPP_RST_CTRL  = 8'h00;
  localparam logic [7:0] LPP_RST_TEST  = 8'h00;
  localparam logic [7:0] LPP_RST_SLEW  = 8'h00;
  localparam logic [7:0] LPP_RST_IRQEN = 8'h00;

  // timing: dominant time limit in microseconds, clock at 100 MHz
  localparam int LPP_CLK_MHZ        = 100;
  localparam int LPP_DOM_LIMIT_US   = 12000;
  localparam int LPP_DOM_LIMIT_CYC  = LPP_DOM_LIMIT_US * LPP_CLK_MHZ;
  localparam int LPP_CNT_W          = 24;

  // slew decode
  typedef enum logic [1:0] {
    LPP_SLEW_NORMAL = 2'h0,
    LPP_SLEW_SLOW   = 2'h1,
    LPP_SLEW_FAST   = 2'h2,
    LPP_SLEW_RSVD   = 2'h3
  } lpp_slew_type;

  // transceiver modes
  typedef enum logic [1:0] {
    LPP_MODE_SHUTDOWN,
    LPP_MODE_NORMAL,
    LPP_MODE_RECEIVE_ONLY_SEL
  } lpp_mode_type;

  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } lpp_req_type;

  // slew decode to driver strobes
  typedef struct packed {
    logic slow;
    logic normal;
    logic fast;
  } lpp_slew_sel_type;

endpackage : lpp_pkg

// ### core/lpp_ctrl.sv
// bus phy protection: config, status and protection flag logic
`timescale 1ns/1ns
`default_nettype none
module lpp_ctrl
  import lpp_pkg::*;
#(
  parameter int DOM_LIMIT_CYC = LPP_DOM_LIMIT_CYC
) (
  input  wire logic              i_clk,
  input  wire logic              i_srst,
  input  wire lpp_req_type       i_req,
  input  wire logic              i_special_mode,
  input  wire logic              i_phy_tx_in,
  input  wire logic              i_overcurrent,
  output logic      [7:0]        o_rdata,
  output logic                   o_irq,
  output logic                   o_tx_enable,
  output lpp_mode_type           o_mode,
  output lpp_slew_sel_type       o_slew_sel,
  output logic      [7:0]        o_test_bits
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // write strobe to one register offset
  function automatic logic wr_hit(input lpp_req_type r, input logic [2:0] off);
    wr_hit = r.wr && (r.addr == off);
  endfunction : wr_hit

  // slew code to one-hot driver strobes; reserved drives none
  function automatic lpp_slew_sel_type slew_decode(input logic [1:0] code);
    lpp_slew_sel_type s;
    s = '0;
    unique case (lpp_slew_type'(code))
      LPP_SLEW_NORMAL: s.normal = 1'b1;
      LPP_SLEW_SLOW:   s.slow   = 1'b1;
      LPP_SLEW_FAST:   s.fast   = 1'b1;
      LPP_SLEW_RSVD:   s        = '0;
    endcase
    slew_decode = s;
  endfunction : slew_decode

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  logic                 phy_enable_r;
  logic                 receive_only_sel_r;
  logic                 tx_timeout_disable_r;
  logic [1:0]           slew_select_r;
  logic [7:0]           test_r;
  logic                 tx_timeout_irq_en_r;
  logic                 overcurrent_irq_en_r;
  logic                 tx_timeout_flag_r;
  logic                 overcurrent_flag_r;
  logic                 tx_still_dominant_r;
  logic                 tx_in_d_r;
  logic [LPP_CNT_W-1:0] dom_cnt_r;
  logic                 mon_active;
  logic                 tx_fall;
  logic                 dom_expired;
  logic                 clr_to;
  logic                 clr_oc;
  logic                 oc_event;
  logic                 oc_block_r;
  logic [7:0]           rdata_nxt;

  // control register: enable and receive-only select
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      phy_enable_r       <= LPP_RST_CTRL[LPP_BIT_ENABLE];
      receive_only_sel_r <= LPP_RST_CTRL[LPP_BIT_RECEIVE_ONLY_SEL];
    end else if (wr_hit(i_req, LPP_OFF_CTRL)) begin
      phy_enable_r       <= i_req.wdata[LPP_BIT_ENABLE];
      receive_only_sel_r <= i_req.wdata[LPP_BIT_RECEIVE_ONLY_SEL];
    end
  end

  // slew and timeout config: locked while enabled so the driver never sees a change mid-frame
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tx_timeout_disable_r <= LPP_RST_SLEW[LPP_BIT_TODIS];
      slew_select_r        <= LPP_RST_SLEW[LPP_BIT_SLEW_HI:LPP_BIT_SLEW_LO];
    end else if (wr_hit(i_req, LPP_OFF_SLEW) && !phy_enable_r) begin
      tx_timeout_disable_r <= i_req.wdata[LPP_BIT_TODIS];
      slew_select_r        <= i_req.wdata[LPP_BIT_SLEW_HI:LPP_BIT_SLEW_LO];
    end
  end

  // factory test register
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      test_r <= LPP_RST_TEST;
    end else if (wr_hit(i_req, LPP_OFF_TEST) && i_special_mode) begin
      test_r <= i_req.wdata;
    end
  end

  // interrupt enables
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tx_timeout_irq_en_r  <= LPP_RST_IRQEN[LPP_BIT_TO];
      overcurrent_irq_en_r <= LPP_RST_IRQEN[LPP_BIT_OC];
    end else if (wr_hit(i_req, LPP_OFF_IRQ_EN)) begin
      tx_timeout_irq_en_r  <= i_req.wdata[LPP_BIT_TO];
      overcurrent_irq_en_r <= i_req.wdata[LPP_BIT_OC];
    end
  end

  // ----------------------------------------------------------------
  // dominant timeout monitor
  // ----------------------------------------------------------------

  // only normal mode with protection on watches the transmit input
  assign mon_active  = phy_enable_r && !receive_only_sel_r && !tx_timeout_disable_r;
  assign tx_fall     = tx_in_d_r && !i_phy_tx_in;
  assign dom_expired = (dom_cnt_r >= LPP_CNT_W'(DOM_LIMIT_CYC - 1)) && !i_phy_tx_in;
  assign clr_to      = wr_hit(i_req, LPP_OFF_IRQ_FLAG) && i_req.wdata[LPP_BIT_TO];
  assign clr_oc      = wr_hit(i_req, LPP_OFF_IRQ_FLAG) && i_req.wdata[LPP_BIT_OC];

  // previous transmit level for edge detection
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tx_in_d_r <= 1'b1;
    end else begin
      tx_in_d_r <= i_phy_tx_in;
    end
  end

  // cycle counter of dominant time; saturates at DOM_LIMIT_CYC - 1, the expiry count
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      dom_cnt_r <= '0;
    end else if (!mon_active || i_phy_tx_in || tx_fall) begin
      dom_cnt_r <= '0;
    end else if (!dom_expired) begin
      dom_cnt_r <= dom_cnt_r + LPP_CNT_W'(1);
    end
  end

  // timeout flag: set beats clear, so a clear while still dominant re-sets it
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tx_timeout_flag_r <= 1'b0;
    end else if (mon_active && dom_expired) begin
      tx_timeout_flag_r <= 1'b1;
    end else if (clr_to) begin
      tx_timeout_flag_r <= 1'b0;
    end
  end

  // still-dominant status: held from timeout until the input goes recessive
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tx_still_dominant_r <= 1'b0;
    end else if (i_phy_tx_in) begin
      tx_still_dominant_r <= 1'b0;
    end else if (mon_active && dom_expired) begin
      tx_still_dominant_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // overcurrent protection
  // ----------------------------------------------------------------

  // input is the already qualified event; masking window lives in the analog side
  assign oc_event = i_overcurrent && phy_enable_r && !receive_only_sel_r;

  // overcurrent flag: re-set if cause persists or tx dominant at the clear
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      overcurrent_flag_r <= 1'b0;
    end else if (oc_event || (clr_oc && overcurrent_flag_r && oc_block_r && !i_phy_tx_in)) begin
      overcurrent_flag_r <= 1'b1;
    end else if (clr_oc) begin
      overcurrent_flag_r <= 1'b0;
    end
  end

  // overcurrent shutdown latch; released only by a clean clear
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      oc_block_r <= 1'b0;
    end else if (oc_event) begin
      oc_block_r <= 1'b1;
    end else if (clr_oc && !i_phy_tx_in) begin
      oc_block_r <= 1'b1;
    end else if (clr_oc) begin
      oc_block_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // transmitter gate: off outside normal mode, on timeout or overcurrent
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_tx_enable <= 1'b0;
    end else begin
      o_tx_enable <= phy_enable_r && !receive_only_sel_r
                     && !(mon_active && dom_expired)
                     && !tx_timeout_flag_r && !tx_still_dominant_r
                     && !oc_event && !oc_block_r;
    end
  end

  // merged level interrupt
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= (tx_timeout_flag_r && tx_timeout_irq_en_r)
               || (overcurrent_flag_r && overcurrent_irq_en_r);
    end
  end

  // mode and driver settings
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_mode      <= LPP_MODE_SHUTDOWN;
      o_slew_sel  <= '0;
      o_test_bits <= LPP_RST_TEST;
    end else begin
      if (!phy_enable_r) begin
        o_mode <= LPP_MODE_SHUTDOWN;
      end else if (receive_only_sel_r) begin
        o_mode <= LPP_MODE_RECEIVE_ONLY_SEL;
      end else begin
        o_mode <= LPP_MODE_NORMAL;
      end
      o_slew_sel  <= slew_decode(slew_select_r);
      o_test_bits <= test_r;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (i_req.addr)
      LPP_OFF_CTRL: begin
        rdata_nxt[LPP_BIT_ENABLE] = phy_enable_r;
        rdata_nxt[LPP_BIT_RECEIVE_ONLY_SEL] = receive_only_sel_r;
      end
      LPP_OFF_TEST: rdata_nxt = test_r;
      LPP_OFF_SLEW: begin
        rdata_nxt[LPP_BIT_TODIS]                   = tx_timeout_disable_r;
        rdata_nxt[LPP_BIT_SLEW_HI:LPP_BIT_SLEW_LO] = slew_select_r;
      end
      LPP_OFF_STATUS: rdata_nxt[LPP_BIT_STILLDOM] = tx_still_dominant_r;
      LPP_OFF_IRQ_EN: begin
        rdata_nxt[LPP_BIT_TO] = tx_timeout_irq_en_r;
        rdata_nxt[LPP_BIT_OC] = overcurrent_irq_en_r;
      end
      LPP_OFF_IRQ_FLAG: begin
        rdata_nxt[LPP_BIT_TO] = tx_timeout_flag_r;
        rdata_nxt[LPP_BIT_OC] = overcurrent_flag_r;
      end
      default: rdata_nxt = 8'h00;
    endcase
  end

  // read data stands one cycle after the read strobe only
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= 8'h00;
    end else if (i_req.rd) begin
      o_rdata <= rdata_nxt;
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule : lpp_ctrl
`default_nettype wire

// ### tb/lpp_ctrl_properties.sv
// checker: port-level properties of the protection block
`timescale 1ns/1ns
`default_nettype none
module lpp_ctrl_properties
  import lpp_pkg::*;
#(
  parameter int DOM_LIMIT_CYC = 16
) (
  input wire logic             i_clk,
  input wire logic             i_srst,
  input wire lpp_req_type      i_req,
  input wire logic             i_special_mode,
  input wire logic             i_phy_tx_in,
  input wire logic             i_overcurrent,
  input wire logic [7:0]       o_rdata,
  input wire logic             o_irq,
  input wire logic             o_tx_enable,
  input wire lpp_mode_type     o_mode,
  input wire lpp_slew_sel_type o_slew_sel,
  input wire logic [7:0]       o_test_bits
);
  // ----
  // helpers
  // ----
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  logic todis_r;
  logic en_r;
  int   dom_cnt_r;
  // shadow of the enable bit; o_mode lags it a cycle, too late to gate writes
  always_ff @(posedge i_clk)
    if (i_srst) en_r <= 1'b0;
    else if (i_req.wr && i_req.addr == LPP_OFF_CTRL) en_r <= i_req.wdata[LPP_BIT_ENABLE];
  // shadow of timeout disable; only shutdown writes land
  always_ff @(posedge i_clk)
    if (i_srst) todis_r <= 1'b0;
    else if (i_req.wr && i_req.addr == LPP_OFF_SLEW && !en_r)
      todis_r <= i_req.wdata[LPP_BIT_TODIS];
  // dominant run while monitored; saturates so it fires once
  always_ff @(posedge i_clk)
    if (i_srst || i_phy_tx_in || o_mode != LPP_MODE_NORMAL || todis_r) dom_cnt_r <= 0;
    else if (dom_cnt_r <= DOM_LIMIT_CYC) dom_cnt_r <= dom_cnt_r + 1;
  function automatic lpp_slew_sel_type dec(input logic [1:0] c);
    case (c)
      2'h0: dec = 3'h2;
      2'h1: dec = 3'h4;
      2'h2: dec = 3'h1;
      default: dec = 3'h0;
    endcase
  endfunction : dec
  sequence slew_wr;
    i_req.wr && i_req.addr == LPP_OFF_SLEW;
  endsequence
  sequence test_wr;
    i_req.wr && i_req.addr == LPP_OFF_TEST;
  endsequence
  // ----
  // properties
  // ----
  slew_hold_a: assert property (
    slew_wr ##0 en_r |=> $stable(o_slew_sel)[*2])
    else $error("slew changed while enabled");
  slew_dec_a: assert property (
    slew_wr ##0 !en_r |-> ##2 o_slew_sel == dec($past(i_req.wdata[1:0], 2)))
    else $error("slew decode wrong");
  dom_trip_a: assert property (dom_cnt_r == DOM_LIMIT_CYC |-> ##[0:3] !o_tx_enable)
    else $error("no dominant timeout");
  irq_cause_a: assert property ($rose(o_irq) |-> !$past(o_tx_enable))
    else $error("irq without flag");
  oc_trip_a: assert property (
    i_overcurrent && o_mode == LPP_MODE_NORMAL |=> !o_tx_enable)
    else $error("overcurrent left tx on");
  tx_recover_a: assert property (
    $rose(o_tx_enable)
      && $past(i_req.wr && i_req.addr == LPP_OFF_IRQ_FLAG && i_req.wdata[LPP_BIT_OC], 2)
      |-> $past(i_phy_tx_in, 2) && !$past(i_overcurrent, 2) && !$past(i_overcurrent))
    else $error("tx back with cause present");
  test_guard_a: assert property (test_wr ##0 !i_special_mode |-> ##2 $stable(o_test_bits))
    else $error("test reg written");
  test_write_a: assert property (
    test_wr ##0 i_special_mode |-> ##2 o_test_bits == $past(i_req.wdata, 2))
    else $error("test reg not written");
endmodule : lpp_ctrl_properties
bind lpp_ctrl lpp_ctrl_properties #(.DOM_LIMIT_CYC(DOM_LIMIT_CYC)) lpp_ctrl_properties_inst (
  .i_clk(i_clk), .i_srst(i_srst), .i_req(i_req), .i_special_mode(i_special_mode),
  .i_phy_tx_in(i_phy_tx_in), .i_overcurrent(i_overcurrent), .o_rdata(o_rdata),
  .o_irq(o_irq), .o_tx_enable(o_tx_enable), .o_mode(o_mode), .o_slew_sel(o_slew_sel),
  .o_test_bits(o_test_bits));
`default_nettype wire

// ### tb/lpp_partner.sv
// partner: serial controller and sense driving tx input and overcurrent
`timescale 1ns/1ns
`default_nettype none
module lpp_partner (
  input  wire logic i_clk,
  output var  logic o_tx,
  output var  logic o_oc
);
  // ----
  // levels
  // ----
  // recessive and fault free until a scenario says otherwise
  initial begin
    o_tx = 1'b1;
    o_oc = 1'b0;
  end
  // levels move just after an edge, like a shifter output
  task automatic set_tx(input logic v);
    @(posedge i_clk);
    o_tx <= v;
  endtask : set_tx
  task automatic set_oc(input logic v);
    @(posedge i_clk);
    o_oc <= v;
  endtask : set_oc
endmodule : lpp_partner
`default_nettype wire

// ### tb/lpp_ctrl_test.sv
// testbench: registers, timeout and overcurrent of the protection block
`timescale 1ns/1ns
`default_nettype none
module lpp_ctrl_test
  import lpp_pkg::*;
;
  // ----
  // signals and instances
  // ----
  logic             i_clk = 0, i_srst = 1, spec = 0, pend = 0;
  lpp_req_type      req = '0;
  logic [7:0]       rdata, tbits, d;
  logic             irq, txen, tx, oc;
  lpp_mode_type     mode;
  lpp_slew_sel_type slew;
  logic [7:0]       exp_q[$];
  int               fails = 0, num_checks = 0, seed = 50377;
  always #5 i_clk = ~i_clk;
  lpp_ctrl #(.DOM_LIMIT_CYC(16)) lpp_ctrl_inst (
    .i_clk(i_clk), .i_srst(i_srst), .i_req(req), .i_special_mode(spec), .i_phy_tx_in(tx),
    .i_overcurrent(oc), .o_rdata(rdata), .o_irq(irq), .o_tx_enable(txen),
    .o_mode(mode), .o_slew_sel(slew), .o_test_bits(tbits));
  lpp_partner lpp_partner_inst (.i_clk(i_clk), .o_tx(tx), .o_oc(oc));
  // ----
  // tasks
  // ----
  task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t read %h exp %h", $time, g, e);
    end
  endtask : cmp_rd
  task automatic cmp_pin(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t pins %h exp %h", $time, g, e);
    end
  endtask : cmp_pin
  // one-cycle strobe; a read notes what it expects
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] v);
    @(posedge i_clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: w ? v : 8'h00};
    if (!w) exp_q.push_back(v);
    @(posedge i_clk);
    req <= '0;
  endtask : bus
  // ends mid-cycle so pins are settled when looked at
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask : cyc
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // read data stand one cycle after the strobe; oldest note pairs up
  always @(posedge i_clk) pend <= req.rd;
  always @(negedge i_clk)
    if (pend) cmp_rd(rdata, exp_q.pop_front());
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    cyc(4000);
    fails++;
    wrap_up();
  end
  // ----
  // scenarios
  // ----
  initial begin
    repeat (8) @(posedge i_clk);
    i_srst <= 1'b0;
    for (int a = 1; a < 8; a++) bus(0, a[2:0], 8'h00);
    for (int c = 0; c < 4; c++) begin
      bus(1, LPP_OFF_SLEW, 8'(c));
      cyc(2);
      cmp_pin(8'(slew), c == 0 ? 8'h02 : c == 1 ? 8'h04 : c == 2 ? 8'h01 : 8'h00);
      bus(0, LPP_OFF_SLEW, 8'(c));
    end
    d = 8'($random(seed));
    bus(1, LPP_OFF_IRQ_EN, d);
    bus(0, LPP_OFF_IRQ_EN, {d[7:6], 6'h00});
    bus(1, LPP_OFF_TEST, 8'h5a);
    bus(0, LPP_OFF_TEST, 8'h00);
    spec <= 1'b1;
    bus(1, LPP_OFF_TEST, 8'ha5);
    spec <= 1'b0;
    cyc(1);
    cmp_pin(tbits, 8'ha5);
    // protection off for a pulse-width use, then back on
    bus(1, LPP_OFF_SLEW, 8'h80);
    bus(1, LPP_OFF_CTRL, 8'h08);
    lpp_partner_inst.set_tx(1'b0);
    cyc(24);
    cmp_pin(8'(mode), 8'(LPP_MODE_NORMAL));
    bus(0, LPP_OFF_IRQ_FLAG, 8'h00);
    lpp_partner_inst.set_tx(1'b1);
    bus(1, LPP_OFF_CTRL, 8'h00);
    bus(1, LPP_OFF_SLEW, 8'h00);
    bus(1, LPP_OFF_CTRL, 8'h08);
    bus(1, LPP_OFF_SLEW, 8'h83);
    bus(0, LPP_OFF_SLEW, 8'h00);
    // dominant timeout, held through a clear attempt
    bus(1, LPP_OFF_IRQ_EN, 8'h80);
    lpp_partner_inst.set_tx(1'b0);
    cyc(24);
    cmp_pin({6'h00, txen, irq}, 8'h01);
    bus(0, LPP_OFF_STATUS, 8'h80);
    bus(0, LPP_OFF_IRQ_FLAG, 8'h80);
    bus(1, LPP_OFF_IRQ_FLAG, 8'h00);
    bus(1, LPP_OFF_IRQ_FLAG, 8'h80);
    cyc(2);
    bus(0, LPP_OFF_IRQ_FLAG, 8'h80);
    bus(1, LPP_OFF_IRQ_EN, 8'h40);
    cyc(2);
    cmp_pin({6'h00, txen, irq}, 8'h00);
    lpp_partner_inst.set_tx(1'b1);
    cyc(2);
    bus(0, LPP_OFF_STATUS, 8'h00);
    bus(1, LPP_OFF_IRQ_FLAG, 8'h80);
    cyc(2);
    cmp_pin({6'h00, txen, irq}, 8'h02);
    // overcurrent, persisting and then with tx dominant at clear
    lpp_partner_inst.set_oc(1'b1);
    cyc(2);
    cmp_pin({6'h00, txen, irq}, 8'h01);
    bus(0, LPP_OFF_IRQ_FLAG, 8'h40);
    bus(1, LPP_OFF_IRQ_FLAG, 8'h40);
    cyc(2);
    bus(0, LPP_OFF_IRQ_FLAG, 8'h40);
    lpp_partner_inst.set_oc(1'b0);
    lpp_partner_inst.set_tx(1'b0);
    bus(1, LPP_OFF_IRQ_FLAG, 8'h40);
    cyc(2);
    bus(0, LPP_OFF_IRQ_FLAG, 8'h40);
    lpp_partner_inst.set_tx(1'b1);
    bus(1, LPP_OFF_IRQ_FLAG, 8'h40);
    cyc(2);
    bus(0, LPP_OFF_IRQ_FLAG, 8'h00);
    cyc(0);
    cmp_pin({6'h00, txen, irq}, 8'h02);
    // receive only: long dominant is not watched
    bus(1, LPP_OFF_CTRL, 8'h0c);
    lpp_partner_inst.set_tx(1'b0);
    cyc(24);
    cmp_pin(8'(mode), 8'(LPP_MODE_RECEIVE_ONLY_SEL));
    bus(0, LPP_OFF_IRQ_FLAG, 8'h00);
    lpp_partner_inst.set_tx(1'b1);
    cyc(2);
    wrap_up();
  end
endmodule : lpp_ctrl_test
`default_nettype wire
